// ===== hw/flash_map_pkg.sv
// constants for the flash partition map: register offsets, config bit positions, region sizes
// assumes a 32-bit apb slave port and one system clock domain
package flash_map_pkg;
	// ****************************************************
	// register offsets (byte addresses)
	// ****************************************************
	localparam logic [31:0] CTRL_OFS   = 32'h0000_0000;
	localparam logic [31:0] STAT_OFS   = 32'h0000_0004;
	localparam logic [31:0] DBASE_OFS  = 32'h0000_0008;
	localparam logic [31:0] ASIZE_OFS  = 32'h0000_000c;
	localparam logic [31:0] ERASE_OFS  = 32'h0000_0010;
	localparam logic [31:0] DSIZE_OFS  = 32'h0000_0014;
	// ****************************************************
	// field positions and reset values
	// ****************************************************
	localparam int          CTRL_EXEC_BIT  = 0;
	localparam int          CFG_DATA_REGION_FLAG_BIT   = 0;
	localparam int          CFG_VAR_BIT    = 2;
	localparam int          CFG_BOOT_BIT   = 7;
	localparam logic        BOOT_APP_VAL   = 1'b1;
	localparam logic        EXEC_RST       = 1'b0;
	// ****************************************************
	// region geometry
	// ****************************************************
	localparam logic [31:0] APP_FULL       = 32'h0001_1000;
	localparam logic [31:0] APP_VAR        = 32'h0001_0000;
	localparam logic [31:0] DATA_FIX_BASE  = 32'h0001_f000;
	localparam logic [31:0] DATA_FIX_SIZE  = 32'h0000_1000;
	localparam logic [31:0] LOADER_SIZE    = 32'h0000_1000;
	localparam logic [31:0] LOADER_BASE    = 32'h0010_0000;
	localparam logic [31:0] CODE_TOP       = 32'h0002_0000;
	localparam int          PAGE_BITS      = 9;
	localparam logic [31:0] PAGE_BYTES     = 32'h0000_0200;
	// ****************************************************
	// types
	// ****************************************************
	typedef enum logic [1:0] {
		ST_LATCH = 2'b00,
		ST_RUN   = 2'b01
	} map_state_t;
	typedef enum logic [1:0] {
		RG_NONE   = 2'b00,
		RG_APP    = 2'b01,
		RG_LOADER = 2'b11,
		RG_DATA   = 2'b10
	} region_t;
endpackage

// ===== hw/flash_partition_map.sv
// flash partition map: boot source, region sizing, fetch routing, page erase targets
// assumes config words are stable from flash at reset release and an apb master
`timescale 1ns/1ps
module flash_partition_map (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] config_word_first,
	input  wire logic [31:0] config_word_second,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_addr,
	output logic             fetch_ready,
	output logic             rd_valid,
	output logic [1:0]       rd_region,
	output logic [31:0]      rd_offset,
	output logic             rd_fault,
	output logic             erase_req,
	output logic [31:0]      erase_addr
);
	// ****************************************************
	// configuration latch
	// ****************************************************
	flash_map_pkg::map_state_t state_q, state_d;
	logic        boot_app_q, boot_app_d;
	logic        var_q, var_d;
	logic        data_region_flag_q, data_region_flag_d;
	logic [31:0] data_base_q, data_base_d;
	logic [31:0] data_size_q, data_size_d;
	logic [31:0] app_size_q, app_size_d;
	logic [31:0] base_aligned;
	logic        run;

	page_align #(.PAGE_BITS(flash_map_pkg::PAGE_BITS)) u_base_align (
		.addr      (config_word_second),
		.page_addr (base_aligned)
	);

	assign run = (state_q == flash_map_pkg::ST_RUN);

	always_comb begin
		state_d     = state_q;
		boot_app_d  = boot_app_q;
		var_d       = var_q;
		data_region_flag_d      = data_region_flag_q;
		data_base_d = data_base_q;
		data_size_d = data_size_q;
		app_size_d  = app_size_q;
		case (state_q)
			flash_map_pkg::ST_LATCH: begin
				// capture once, then never again until reset
				boot_app_d = config_word_first[flash_map_pkg::CFG_BOOT_BIT];
				var_d      = config_word_first[flash_map_pkg::CFG_VAR_BIT];
				data_region_flag_d     = config_word_first[flash_map_pkg::CFG_DATA_REGION_FLAG_BIT];
				if (config_word_first[flash_map_pkg::CFG_VAR_BIT]) begin
					data_base_d = flash_map_pkg::DATA_FIX_BASE;
					data_size_d = flash_map_pkg::DATA_FIX_SIZE;
					app_size_d  = flash_map_pkg::APP_VAR;
				end else if (config_word_first[flash_map_pkg::CFG_DATA_REGION_FLAG_BIT]) begin
					data_base_d = flash_map_pkg::APP_FULL;
					data_size_d = 32'h0000_0000;
					app_size_d  = flash_map_pkg::APP_FULL;
				end else begin
					// a base past the shared space leaves no data region
					if (base_aligned > flash_map_pkg::APP_FULL) begin
						data_base_d = flash_map_pkg::APP_FULL;
					end else begin
						data_base_d = base_aligned;
					end
					app_size_d  = data_base_d;
					data_size_d = flash_map_pkg::APP_FULL - data_base_d;
				end
				state_d = flash_map_pkg::ST_RUN;
			end
			flash_map_pkg::ST_RUN: begin
				state_d = flash_map_pkg::ST_RUN;
			end
			default: begin
				state_d = flash_map_pkg::ST_LATCH;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q     <= flash_map_pkg::ST_LATCH;
			boot_app_q  <= 1'b0;
			var_q       <= 1'b0;
			data_region_flag_q      <= 1'b0;
			data_base_q <= 32'h0000_0000;
			data_size_q <= 32'h0000_0000;
			app_size_q  <= 32'h0000_0000;
		end else begin
			state_q     <= state_d;
			boot_app_q  <= boot_app_d;
			var_q       <= var_d;
			data_region_flag_q      <= data_region_flag_d;
			data_base_q <= data_base_d;
			data_size_q <= data_size_d;
			app_size_q  <= app_size_d;
		end
	end

	// ****************************************************
	// apb slave
	// ****************************************************
	logic        exec_loader_q, exec_loader_d;
	logic [31:0] prdata_q, prdata_d;
	logic        erase_req_q, erase_req_d;
	logic [31:0] erase_addr_q, erase_addr_d;
	logic [31:0] wr_page;
	logic        access;
	logic        mapped;

	page_align #(.PAGE_BITS(flash_map_pkg::PAGE_BITS)) u_erase_align (
		.addr      (pwdata),
		.page_addr (wr_page)
	);

	assign access = psel && penable;
	assign pready = 1'b1;
	assign mapped = (paddr == flash_map_pkg::CTRL_OFS) || (paddr == flash_map_pkg::STAT_OFS) ||
		(paddr == flash_map_pkg::DBASE_OFS) || (paddr == flash_map_pkg::ASIZE_OFS) ||
		(paddr == flash_map_pkg::ERASE_OFS) || (paddr == flash_map_pkg::DSIZE_OFS);
	assign pslverr = access && !mapped;
	assign prdata  = prdata_q;

	always_comb begin
		exec_loader_d = exec_loader_q;
		prdata_d      = prdata_q;
		erase_req_d   = 1'b0;
		erase_addr_d  = erase_addr_q;
		if (state_q == flash_map_pkg::ST_LATCH) begin
			exec_loader_d = (config_word_first[flash_map_pkg::CFG_BOOT_BIT]
				!= flash_map_pkg::BOOT_APP_VAL);
		end else if (access && pwrite) begin
			if (paddr == flash_map_pkg::CTRL_OFS) begin
				// takes effect on the next fetch, no reset needed
				exec_loader_d = pwdata[flash_map_pkg::CTRL_EXEC_BIT];
			end
			if (paddr == flash_map_pkg::ERASE_OFS) begin
				erase_addr_d = wr_page;
				erase_req_d  = 1'b1;
			end
		end
		if (psel && !penable) begin
			case (paddr)
				flash_map_pkg::CTRL_OFS:  prdata_d = {31'h0000_0000, exec_loader_q};
				flash_map_pkg::STAT_OFS:  prdata_d = {27'h000_0000, boot_app_q, var_q,
					data_region_flag_q, 1'b0, run};
				flash_map_pkg::DBASE_OFS: prdata_d = data_base_q;
				flash_map_pkg::ASIZE_OFS: prdata_d = app_size_q;
				flash_map_pkg::ERASE_OFS: prdata_d = erase_addr_q;
				flash_map_pkg::DSIZE_OFS: prdata_d = data_size_q;
				default:                  prdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			exec_loader_q <= flash_map_pkg::EXEC_RST;
			prdata_q      <= 32'h0000_0000;
			erase_req_q   <= 1'b0;
			erase_addr_q  <= 32'h0000_0000;
		end else begin
			exec_loader_q <= exec_loader_d;
			prdata_q      <= prdata_d;
			erase_req_q   <= erase_req_d;
			erase_addr_q  <= erase_addr_d;
		end
	end

	assign erase_req  = erase_req_q;
	assign erase_addr = erase_addr_q;

	// ****************************************************
	// fetch routing
	// ****************************************************
	logic        rd_valid_q, rd_valid_d;
	logic [1:0]  rd_region_q, rd_region_d;
	logic [31:0] rd_offset_q, rd_offset_d;
	logic        rd_fault_q, rd_fault_d;

	// every cycle in ST_RUN takes a new address, so a linear stream never stalls
	assign fetch_ready = run;

	always_comb begin
		rd_valid_d  = fetch_valid && run;
		rd_region_d = flash_map_pkg::RG_NONE;
		rd_offset_d = 32'h0000_0000;
		rd_fault_d  = 1'b0;
		if (fetch_valid && run) begin
			if (fetch_addr >= flash_map_pkg::LOADER_BASE &&
				fetch_addr < flash_map_pkg::LOADER_BASE + flash_map_pkg::LOADER_SIZE) begin
				rd_region_d = flash_map_pkg::RG_LOADER;
				rd_offset_d = fetch_addr - flash_map_pkg::LOADER_BASE;
			end else if (exec_loader_q && fetch_addr < flash_map_pkg::LOADER_SIZE) begin
				rd_region_d = flash_map_pkg::RG_LOADER;
				rd_offset_d = fetch_addr;
			end else if (!exec_loader_q && fetch_addr < app_size_q) begin
				rd_region_d = flash_map_pkg::RG_APP;
				rd_offset_d = fetch_addr;
			end else if (data_size_q != 32'h0000_0000 && fetch_addr >= data_base_q &&
				fetch_addr < data_base_q + data_size_q) begin
				rd_region_d = flash_map_pkg::RG_DATA;
				rd_offset_d = fetch_addr - data_base_q;
			end else begin
				rd_fault_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_valid_q  <= 1'b0;
			rd_region_q <= flash_map_pkg::RG_NONE;
			rd_offset_q <= 32'h0000_0000;
			rd_fault_q  <= 1'b0;
		end else begin
			rd_valid_q  <= rd_valid_d;
			rd_region_q <= rd_region_d;
			rd_offset_q <= rd_offset_d;
			rd_fault_q  <= rd_fault_d;
		end
	end

	assign rd_valid  = rd_valid_q;
	assign rd_region = rd_region_q;
	assign rd_offset = rd_offset_q;
	assign rd_fault  = rd_fault_q;

	// ****************************************************
	// checks
	// ****************************************************
	AST_BOOT_SEL: assert property (@(posedge mclk) disable iff (rst)
		$rose(run) |-> exec_loader_q == !boot_app_q)
		else $error("boot region does not follow boot select");
	AST_VAR_FIXED: assert property (@(posedge mclk) disable iff (rst)
		run && var_q |-> data_base_q == 32'h0001_f000 && data_size_q == 32'h0000_1000
		&& app_size_q == 32'h0001_0000)
		else $error("variable data region not fixed at 4K");
	AST_NO_DATA: assert property (@(posedge mclk) disable iff (rst)
		run && !var_q && data_region_flag_q |-> data_size_q == 32'h0 && app_size_q == 32'h0001_1000)
		else $error("data region present when disabled");
	AST_SHARED: assert property (@(posedge mclk) disable iff (rst)
		run && !var_q && !data_region_flag_q |-> app_size_q + data_size_q == 32'h0001_1000
		&& data_base_q == app_size_q)
		else $error("shared space does not add up");
	AST_ERASE_PAGE: assert property (@(posedge mclk) disable iff (rst)
		access && pwrite && paddr == flash_map_pkg::ERASE_OFS && run
		|=> erase_req && erase_addr == {$past(pwdata[31:9]), 9'h000} ##1 !erase_req)
		else $error("erase pulse or page address wrong");
	AST_ZERO_WAIT: assert property (@(posedge mclk) disable iff (rst)
		fetch_valid && fetch_ready |=> rd_valid ##0 (rd_fault || rd_offset[1:0]
		== $past(fetch_addr[1:0]) || rd_region == flash_map_pkg::RG_DATA))
		else $error("fetch not answered next cycle");
	AST_SWITCH: assert property (@(posedge mclk) disable iff (rst)
		run && access && pwrite && paddr == flash_map_pkg::CTRL_OFS
		|=> exec_loader_q == $past(pwdata[0]))
		else $error("region switch not taken");
	AST_LOADER_SIZE: assert property (@(posedge mclk) disable iff (rst)
		rd_valid && rd_region == flash_map_pkg::RG_LOADER |-> rd_offset < 32'h0000_1000)
		else $error("loader offset past 4KB");
	// the release edge itself still holds the flops in reset, so start one edge later
	AST_LATCH_FIRST: assert property (@(posedge mclk) disable iff (rst)
		!run && !rst |-> !fetch_ready ##1 run)
		else $error("fetch served before config latched");
	AST_ALIGN: assert property (@(posedge mclk) disable iff (rst)
		erase_req |-> erase_addr[8:0] == 9'h000)
		else $error("erase address not page aligned");
endmodule // flash_partition_map

// ===== hw/page_align.sv
// page alignment of a byte address
// assumes the page size is a power of two given as a bit count
`timescale 1ns/1ps
module page_align #(
	parameter int PAGE_BITS = 9
) (
	input  wire logic [31:0] addr,
	output wire logic [31:0] page_addr
);
	// low bits inside the page are dropped, never rounded up
	assign page_addr = {addr[31:PAGE_BITS], {PAGE_BITS{1'b0}}};
endmodule // page_align

// ===== testbench/fetch_core_model.sv
// processor-side fetch model: issues word fetches and holds each until accepted
// assumes one clock shared with the partition map; requests change just after a rising edge
`timescale 1ns/1ps
module fetch_core_model (
	input  wire logic        mclk,
	input  wire logic        fetch_ready,
	output logic             fetch_valid,
	output logic [31:0]      fetch_addr
);
	// ****************************************************
	// request driver
	// ****************************************************
	initial begin
		fetch_valid = 1'b0;
		fetch_addr  = 32'h0000_0000;
	end
	// holds the request until the edge that takes it; back-to-back calls give one per cycle
	task automatic fetch(input logic [31:0] a);
		fetch_valid <= 1'b1;
		fetch_addr  <= a;
		do @(posedge mclk); while (fetch_ready !== 1'b1);
	endtask
	// released address shows the inverse so a stale value cannot pass for a request
	task automatic idle();
		fetch_valid <= 1'b0;
		fetch_addr  <= ~fetch_addr;
	endtask
endmodule // fetch_core_model

// ===== testbench/tb.sv
// self-checking bench for the flash partition map: config modes, fetch routing, erase, apb
// assumes flash_map_pkg is compiled first; drives apb and config words, checks against a model
`timescale 1ns/1ps
module tb;
	logic        mclk, rst, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, cw1, cw2;
	wire  [31:0] prdata, fetch_addr, rd_offset, erase_addr;
	wire         pready, pslverr, fetch_valid, fetch_ready, rd_valid, rd_fault, erase_req;
	wire  [1:0]  rd_region;
	int          n_fail, n_tests;
	logic        ex;
	logic [31:0] asz, dsz, db, c1, a, rdv;
	logic        er;
	logic [34:0] q[$];
	logic [31:0] al[10];

	flash_partition_map i_flash_partition_map (.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .config_word_first(cw1),
		.config_word_second(cw2), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
		.fetch_ready(fetch_ready), .rd_valid(rd_valid), .rd_region(rd_region),
		.rd_offset(rd_offset), .rd_fault(rd_fault), .erase_req(erase_req),
		.erase_addr(erase_addr));
	fetch_core_model i_fetch_core_model (.mclk(mclk), .fetch_ready(fetch_ready),
		.fetch_valid(fetch_valid), .fetch_addr(fetch_addr));

	// ****************************************************
	// checks and model
	// ****************************************************
	task automatic bad(input string s);
		n_fail++;
		$display("mismatch %0t %s", $time, s);
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) bad($sformatf("value %h expected %h", g, e));
	endtask
	// on a fault the offset carries no meaning, so only the fault flag is compared
	task automatic chk_rd(input logic [34:0] g, input logic [34:0] e);
		n_tests++;
		if (e[34] ? g[34] !== 1'b1 : g !== e) bad($sformatf("fetch %h expected %h", g, e));
	endtask
	function automatic logic [34:0] route(input logic [31:0] x);
		if (x >= flash_map_pkg::LOADER_BASE && x < 32'h0010_1000)
			return {1'b0, flash_map_pkg::RG_LOADER, x - flash_map_pkg::LOADER_BASE};
		if (ex && x < flash_map_pkg::LOADER_SIZE)
			return {1'b0, flash_map_pkg::RG_LOADER, x};
		if (!ex && x < asz)
			return {1'b0, flash_map_pkg::RG_APP, x};
		if (dsz != 0 && x >= db && x < db + dsz)
			return {1'b0, flash_map_pkg::RG_DATA, x - db};
		return {1'b1, 34'h0};
	endfunction
	always @(negedge mclk) begin
		if (rd_valid === 1'b1) begin
			if (q.size() == 0) bad("unrequested fetch result");
			else chk_rd({rd_fault, rd_region, rd_offset}, q.pop_front());
		end
	end

	// ****************************************************
	// bus tasks and sequence
	// ****************************************************
	task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		// one edge between transfers, so a release and the next setup never share a step
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rdv = prdata;
		er  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run_fetches();
		foreach (al[i]) begin
			i_fetch_core_model.fetch(al[i]);
			q.push_back(route(al[i]));
		end
		i_fetch_core_model.idle();
		@(posedge mclk);
	endtask
	task automatic final_report();
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		bad("watchdog expired");
		final_report();
	end
	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, cw1, cw2} = '0;
		rst = 1'b1;
		n_fail = 0;
		n_tests = 0;
		void'($urandom(68));
		for (int k = 0; k < 8; k++) begin
			c1 = $urandom;
			{c1[0], c1[2], c1[7]} = k[2:0];
			rst <= 1'b1;
			cw1 <= c1;
			cw2 <= $urandom & 32'h0001_ffff;
			repeat (3) @(posedge mclk);
			rst <= 1'b0;
			repeat (2) @(posedge mclk);
			ex = !c1[7];
			db = 32'h0;
			dsz = 32'h0;
			asz = flash_map_pkg::APP_FULL;
			if (c1[2]) begin
				asz = flash_map_pkg::APP_VAR;
				db  = flash_map_pkg::DATA_FIX_BASE;
				dsz = flash_map_pkg::DATA_FIX_SIZE;
			end else if (!c1[0]) begin
				db  = cw2 & 32'hffff_fe00;
				if (db > flash_map_pkg::APP_FULL) db = flash_map_pkg::APP_FULL;
				asz = db;
				dsz = flash_map_pkg::APP_FULL - db;
			end
			apb(1'b0, flash_map_pkg::STAT_OFS, 32'h0);
			chk_reg(rdv, {27'h0, c1[7], c1[2], c1[0], 2'b01});
			apb(1'b0, flash_map_pkg::ASIZE_OFS, 32'h0);
			chk_reg(rdv, asz);
			apb(1'b0, flash_map_pkg::DSIZE_OFS, 32'h0);
			chk_reg(rdv, dsz);
			apb(1'b0, flash_map_pkg::DBASE_OFS, 32'h0);
			if (c1[2] || !c1[0]) chk_reg(rdv, db);
			al = '{32'h0, asz - 4, asz, db, db + dsz - 4, db + dsz, 32'h0010_0000,
				32'h0010_0ffc, 32'h0010_1000, $urandom & 32'h0001_fffc};
			run_fetches();
			// software switch to the other region with no reset between
			apb(1'b1, flash_map_pkg::CTRL_OFS, {31'h0, ex ^ 1'b1});
			ex = !ex;
			apb(1'b0, flash_map_pkg::CTRL_OFS, 32'h0);
			chk_reg(rdv, {31'h0, ex});
			al = '{32'h0, 32'h0ffc, 32'h1000, asz - 4, db, 32'h0010_0004,
				$urandom & 32'h0001_fffc, 32'h0800, 32'h0001_f000, 32'h0001_0ffc};
			run_fetches();
			a = $urandom & 32'h0001_ffff;
			apb(1'b1, flash_map_pkg::ERASE_OFS, a);
			@(negedge mclk);
			chk_reg({31'h0, erase_req}, 32'h1);
			chk_reg(erase_addr, a & 32'hffff_fe00);
			@(negedge mclk);
			chk_reg({31'h0, erase_req}, 32'h0);
			apb(1'b0, flash_map_pkg::ERASE_OFS, 32'h0);
			chk_reg(rdv, a & 32'hffff_fe00);
			apb(1'b0, 32'h0000_0018, 32'h0);
			chk_reg({rdv[30:0], er}, 32'h1);
		end
		repeat (3) @(posedge mclk);
		chk_reg(q.size(), 32'h0);
		final_report();
	end
endmodule // tb
